/* mfirq_chk.sv */
/* port checker for mfirq_regs.
   assumes ref_clk clock and srst synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module mfirq_chk (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic [3:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [1:0] timer2_evt,
    input wire logic [1:0] grp_ack,
    input wire logic [5:0] grp_req,
    input wire logic [1:0] ext_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_reset_clear: assert property ($past(srst) |->
        grp_req == 6'h00 && ext_req == 2'h0) else $error("not clear");
    a_unmapped_zero: assert property (rd && addr > 4'h8 |=>
        rdata == 8'h00) else $error("unmapped read");
    a_unimpl_bits: assert property (rd && (addr == 4'h3 || addr == 4'h6)
        |=> (rdata & ($past(addr) == 4'h3 ? 8'h88 : 8'hCC)) == 8'h00)
        else $error("unimplemented bit");
    a_reserved_bits: assert property (rd && (addr == 4'h1 || addr == 4'h5)
        |=> (rdata & 8'h55) == 8'h00) else $error("reserved bit");
    a_grp5_cause: assert property ($rose(grp_req[5]) |->
        $past(wr || timer2_evt != 2'h0)) else $error("group rose alone");
    a_grp5_persist: assert property ($fell(grp_req[5]) |->
        $past(wr)) else $error("group fell alone");
    a_ext_cause: assert property ($rose(ext_req[1]) |->
        $past(wr || grp_req[5])) else $error("ext rose alone");
    a_ack_clears: assert property (grp_ack[1] && !wr && !grp_req[5] &&
        !$past(grp_req[5]) |=> !ext_req[1]) else $error("ack ignored");
    cover property ($rose(ext_req[1]));
    cover property ($fell(ext_req[1]));
    cover property (rd && addr > 4'h8);
endmodule
bind mfirq_regs mfirq_chk mfirq_chk_i (.ref_clk, .srst, .addr, .wr, .rd,
    .rdata, .timer2_evt, .grp_ack, .grp_req, .ext_req);
`default_nettype wire

/* mfirq_evt_model.sv */
/* event source and core ack model for mfirq_regs.
   assumes pulse is called just after a rising ref_clk edge. */
`timescale 1ns/1ns
`default_nettype none
module mfirq_evt_model (
    input  wire logic       ref_clk,
    output var  logic [1:0] grp_ack,
    output var  logic [1:0] touch_mod_evt,
    output var  logic [4:0] touch_cnt_evt,
    output var  logic [1:0] timer2_evt,
    output var  logic [3:0] misc_evt
);
    initial {grp_ack, touch_mod_evt, touch_cnt_evt, timer2_evt, misc_evt} = 0;
    // one-cycle event or service pulse
    task automatic pulse(input logic [14:0] v);
        {grp_ack, touch_mod_evt, touch_cnt_evt, timer2_evt, misc_evt} <= v;
        @(posedge ref_clk);
        {grp_ack, touch_mod_evt, touch_cnt_evt, timer2_evt, misc_evt} <= 0;
    endtask
endmodule
`default_nettype wire

/* mfirq_map.vh */
/*
 register indices, field positions and reset values of the extended
 multi-function interrupt register bank. assumes an 8-bit register port.
*/
// Summary of operation
// - group 5/4 flags bits 7,6; enables 3,2
// - touch 4/3 flags bits 5,4; enables 1,0
// - touch 1/0 counter flags 7,5; enables 3,1
// - timer0 cmp A/P flags 7,6; enables 3,2
// - touch2 counter flag bit 5, enable 1
// - timer1 cmp B/A/P flags 6-4; enables 2-0
// - unimplemented timer1/timer2 bits read zero
// - eeprom, lvd, ext, timebase1 flags 7-4; enables 3-0
// - touch 4/3 counter flags 7,5; enables 3,1
// - timer2 cmp A/P flags 5,4; enables 1,0
// - flag one means pending; enable one permits, except touch 4/3 enables, which gate nothing
// - first enabled member flag pending sets group flag
// - flags set even when enable is zero
// - group service clears only the group flag
`ifndef MFIRQ_MAP_VH
`define MFIRQ_MAP_VH
`define MFIRQ_IDX_EXT      3'h0
`define MFIRQ_IDX_TCLO     3'h1
`define MFIRQ_IDX_TMR0     3'h2
`define MFIRQ_IDX_TMR1     3'h3
`define MFIRQ_IDX_MISC     3'h4
`define MFIRQ_IDX_TCHI     3'h5
`define MFIRQ_IDX_TMR2     3'h6
`define MFIRQ_IDX_STAT     3'h7
`define MFIRQ_IDX_MASK     4'h8
`define MFIRQ_RESET_VAL    8'h00
`define MFIRQ_IMPL_TCLO    8'hAA
`define MFIRQ_IMPL_TMR0    8'hEE
`define MFIRQ_IMPL_TMR1    8'h77
`define MFIRQ_IMPL_MISC    8'hFF
`define MFIRQ_IMPL_TCHI    8'hAA
`define MFIRQ_IMPL_TMR2    8'h33
`define MFIRQ_IMPL_EXT     8'hFF
`define MFIRQ_EXT_G5F      7
`define MFIRQ_EXT_G4F      6
`define MFIRQ_EXT_T4F      5
`define MFIRQ_EXT_T3F      4
`define MFIRQ_EXT_G5E      3
`define MFIRQ_EXT_G4E      2
`define MFIRQ_EXT_T4E      1
`define MFIRQ_EXT_T3E      0
`define MFIRQ_NSRC         6
`endif

/* mfirq_regs.v */
/*
 extended multi-function interrupt register bank with status/mask
 interrupt output. assumes source events are one-cycle pulses from
 logic on ref_clk and a core that pulses grp_ack on vector service.
*/
// The plain strobed port and the address map were decided locally.
`include "mfirq_map.vh"
`timescale 1ns/1ns
`default_nettype none
module mfirq_regs (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire [1:0] touch_mod_evt,
    input  wire [4:0] touch_cnt_evt,
    input  wire [1:0] timer0_evt,
    input  wire [2:0] timer1_evt,
    input  wire [1:0] timer2_evt,
    input  wire [3:0] misc_evt,
    input  wire [1:0] grp_ack,
    output wire [5:0] grp_req,
    output wire [1:0] ext_req,
    output wire       irq
);
    wire [7:0] src_val [0:5];
    wire [5:0] src_rise;
    wire [5:0] src_wr;
    wire [3:0] set_vec [0:5];
    wire [7:0] impl_vec [0:5];
    reg  [7:0] ext_r;
    reg  [7:0] ext_nxt;
    reg  [7:0] stat_r;
    reg  [7:0] mask_r;
    reg  [7:0] stat_nxt;
    wire [7:0] evt_vec;
    reg  [7:0] rd_nxt;

    function wr_hit;
        input [3:0] a;
        input [3:0] idx;
        begin
            wr_hit = (a == idx);
        end
    endfunction

    // flag positions per register, bit 7..4
    assign set_vec[0] = {touch_cnt_evt[1], 1'b0, touch_cnt_evt[0], 1'b0};
    assign set_vec[1] = {timer0_evt[1], timer0_evt[0],
                         touch_cnt_evt[2], 1'b0};
    assign set_vec[2] = {1'b0, timer1_evt};
    assign set_vec[3] = misc_evt;
    assign set_vec[4] = {touch_cnt_evt[4], 1'b0, touch_cnt_evt[3], 1'b0};
    assign set_vec[5] = {2'b00, timer2_evt};
    // reserved bits held at zero whatever software writes
    assign impl_vec[0] = `MFIRQ_IMPL_TCLO;
    assign impl_vec[1] = `MFIRQ_IMPL_TMR0;
    assign impl_vec[2] = `MFIRQ_IMPL_TMR1;
    assign impl_vec[3] = `MFIRQ_IMPL_MISC;
    assign impl_vec[4] = `MFIRQ_IMPL_TCHI;
    assign impl_vec[5] = `MFIRQ_IMPL_TMR2;

    genvar g;
    generate
        for (g = 0; g < `MFIRQ_NSRC; g = g + 1) begin : src
            assign src_wr[g] = wr & wr_hit(addr, g + 1);
            mfirq_src_reg #(
                .IMPL (impl_vec_const(g))
            ) u_reg (
                .ref_clk   (ref_clk),
                .srst      (srst),
                .wr_en     (src_wr[g]),
                .wr_data   (wdata),
                .set_in    (set_vec[g]),
                .value     (src_val[g]),
                .group_req (grp_req[g]),
                .rise      (src_rise[g])
            );
        end
    endgenerate

    function [7:0] impl_vec_const;
        input integer i;
        begin
            case (i)
                0: impl_vec_const = `MFIRQ_IMPL_TCLO;
                1: impl_vec_const = `MFIRQ_IMPL_TMR0;
                2: impl_vec_const = `MFIRQ_IMPL_TMR1;
                3: impl_vec_const = `MFIRQ_IMPL_MISC;
                4: impl_vec_const = `MFIRQ_IMPL_TCHI;
                default: impl_vec_const = `MFIRQ_IMPL_TMR2;
            endcase
        end
    endfunction

    // extended group register
    always @* begin
        ext_nxt = ext_r;
        if (wr && wr_hit(addr, {1'b0, `MFIRQ_IDX_EXT})) begin
            ext_nxt = wdata;
        end
        // group service clears only the group flag
        if (grp_ack[0]) begin
            ext_nxt[`MFIRQ_EXT_G4F] = 1'b0;
        end
        if (grp_ack[1]) begin
            ext_nxt[`MFIRQ_EXT_G5F] = 1'b0;
        end
        // group request (any enabled member flag) rising sets the group flag, set wins
        if (src_rise[4]) begin
            ext_nxt[`MFIRQ_EXT_G4F] = 1'b1;
        end
        if (src_rise[5]) begin
            ext_nxt[`MFIRQ_EXT_G5F] = 1'b1;
        end
        if (touch_mod_evt[0]) begin
            ext_nxt[`MFIRQ_EXT_T3F] = 1'b1;
        end
        if (touch_mod_evt[1]) begin
            ext_nxt[`MFIRQ_EXT_T4F] = 1'b1;
        end
    end

    // flag sets regardless of enable; request gated
    assign ext_req[0] = ext_r[`MFIRQ_EXT_G4F] & ext_r[`MFIRQ_EXT_G4E];
    assign ext_req[1] = ext_r[`MFIRQ_EXT_G5F] & ext_r[`MFIRQ_EXT_G5E];

    // sticky status: group rises, touch events
    assign evt_vec = {touch_mod_evt, src_rise};
    always @* begin
        stat_nxt = stat_r;
        if (wr && wr_hit(addr, {1'b0, `MFIRQ_IDX_STAT})) begin
            stat_nxt = stat_r & ~wdata;
        end
        stat_nxt = stat_nxt | evt_vec;
    end
    assign irq = |(stat_r & mask_r);

    always @* begin
        rd_nxt = 8'h00;
        if (addr == {1'b0, `MFIRQ_IDX_EXT}) begin
            rd_nxt = ext_r;
        end else if (addr == {1'b0, `MFIRQ_IDX_STAT}) begin
            rd_nxt = stat_r;
        end else if (addr == `MFIRQ_IDX_MASK) begin
            rd_nxt = mask_r;
        end else if (addr >= 4'h1 && addr <= 4'h6) begin
            rd_nxt = src_val[addr[2:0] - 3'h1];
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            ext_r  <= `MFIRQ_RESET_VAL;
            stat_r <= `MFIRQ_RESET_VAL;
            mask_r <= `MFIRQ_RESET_VAL;
            rdata  <= 8'h00;
        end else begin
            ext_r  <= ext_nxt;
            stat_r <= stat_nxt;
            if (wr && addr == `MFIRQ_IDX_MASK) begin
                mask_r <= wdata;
            end
            rdata <= rd ? rd_nxt : 8'h00;
        end
    end
endmodule
`default_nettype wire

/* mfirq_src_reg.v */
/*
 one per-source flag/enable register: flags in the high nibble,
 enables in the low nibble. assumes same clock as the register port.
*/
`include "mfirq_map.vh"
`timescale 1ns/1ns
`default_nettype none
module mfirq_src_reg #(
    parameter [7:0] IMPL = 8'hFF
) (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire [3:0] set_in,
    output wire [7:0] value,
    output wire       group_req,
    output wire       rise
);
    reg  [7:0] val_r;
    wire [7:0] val_nxt;
    reg        req_q_r;
    // hardware set wins over software write
    assign val_nxt = ((wr_en ? wr_data : val_r) | {set_in, 4'h0}) & IMPL;
    always @(posedge ref_clk) begin
        if (srst) begin
            val_r   <= `MFIRQ_RESET_VAL;
            req_q_r <= 1'b0;
        end else begin
            val_r   <= val_nxt;
            req_q_r <= group_req;
        end
    end
    assign value = val_r;
    // each flag qualified by its own enable
    assign group_req = |(val_r[7:4] & val_r[3:0]);
    assign rise = group_req & ~req_q_r;
endmodule
`default_nettype wire

/* tb.sv */
/* bench for mfirq_regs over its register port.
   assumes mfirq_evt_model on the event side. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic       ref_clk = 1'b0;
    logic       srst    = 1'b1;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [3:0] addr    = 4'h0;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata;
    logic [1:0] ack, tmod, t2, ext_req;
    logic [4:0] tcnt;
    logic [1:0] t0      = 2'h0;
    logic [2:0] t1      = 3'h0;
    logic [3:0] misc;
    logic [5:0] grp_req;
    logic       irq;
    int         failures = 0, samples_checked = 0, cyc = 0;
    logic [7:0] impl [7] = '{8'hFF, 8'hAA, 8'hEE, 8'h77, 8'hFF, 8'hAA, 8'h33};
    always #20 ref_clk = ~ref_clk;
    mfirq_regs mfirq_regs_i (.ref_clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
        .touch_mod_evt(tmod), .touch_cnt_evt(tcnt), .timer0_evt(t0),
        .timer1_evt(t1), .timer2_evt(t2), .misc_evt(misc), .grp_ack(ack),
        .grp_req, .ext_req, .irq);
    mfirq_evt_model model_i (.ref_clk, .grp_ack(ack), .touch_mod_evt(tmod),
        .touch_cnt_evt(tcnt), .timer2_evt(t2), .misc_evt(misc));
    task check(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 check(rdata, e);
        @(posedge ref_clk);
    endtask
    task give_verdict;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            failures++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 9; i++) rd_chk(4'(i), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 7; i++) wr_reg(4'(i), impl[i] | 8'h88);
        wr_reg(4'h9, 8'hFF);
        for (int i = 0; i < 7; i++) rd_chk(4'(i), impl[i]);
        rd_chk(4'h9, 8'h00);
        rd_chk(4'h7, 8'h3F);
        for (int i = 0; i < 7; i++) wr_reg(4'(i), 8'h00);
        wr_reg(4'h7, 8'hFF);
        rd_chk(4'h7, 8'h00);
        $display("test layout done");
        model_i.pulse(15'h1FFF);
        rd_chk(4'h1, 8'hA0);
        rd_chk(4'h4, 8'hF0);
        rd_chk(4'h5, 8'hA0);
        rd_chk(4'h6, 8'h30);
        rd_chk(4'h0, 8'h30);
        #1 check({2'h0, grp_req}, 8'h00);
        @(posedge ref_clk);
        wr_reg(4'h5, 8'hAA);
        wr_reg(4'h6, 8'h33);
        wr_reg(4'h0, 8'hFC);
        rd_chk(4'h0, 8'hFC);
        rd_chk(4'h7, 8'hF0);
        #1 check({6'h00, ext_req}, 8'h03);
        check({2'h0, grp_req}, 8'h30);
        check({7'h00, irq}, 8'h00);
        @(posedge ref_clk);
        wr_reg(4'h8, 8'h10);
        #1 check({7'h00, irq}, 8'h01);
        @(posedge ref_clk);
        wr_reg(4'h7, 8'h10);
        rd_chk(4'h7, 8'hE0);
        #1 check({7'h00, irq}, 8'h00);
        @(posedge ref_clk);
        $display("test events done");
        wr_reg(4'h6, 8'h03);
        model_i.pulse(15'h4000);
        rd_chk(4'h0, 8'h7C);
        model_i.pulse(15'h2000);
        rd_chk(4'h0, 8'h3C);
        rd_chk(4'h5, 8'hAA);
        t0 <= 2'h3;
        t1 <= 3'h7;
        @(posedge ref_clk);
        t0 <= 2'h0;
        t1 <= 3'h0;
        rd_chk(4'h2, 8'hE0);
        rd_chk(4'h3, 8'h70);
        $display("test service done");
        give_verdict;
    end
endmodule
`default_nettype wire
